// >>> bench/reg_host_model.sv
`timescale 1ns/1ps
module reg_host_model (
  input  wire logic       sys_clk,    // system clock
  input  wire logic [7:0] reg_rdata,  // read data from bank
  input  wire logic       reg_rvalid, // read data valid
  output logic            reg_wr,     // write strobe
  output logic            reg_rd,     // read strobe
  output logic      [7:0] reg_addr,   // register address
  output logic      [7:0] reg_wdata   // write data
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hA5;
    reg_wdata = 8'h5A;
  end

  // idle bus shows inverted values so stale data is never mistaken for live
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    v        = reg_rvalid;
    d        = reg_rdata;
  endtask : read_reg
endmodule : reg_host_model

// >>> bench/test_equalizer_control_register_bank.sv
`timescale 1ns/1ps
module test_equalizer_control_register_bank;
  import eq_regs_pkg::*;
  logic       sys_clk, rst, reg_wr, reg_rd, reg_rvalid, reg_hit, dpin, rngpin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rset;
  logic [6:0] lpin, eff_lvl, mag;
  logic [3:0] rpin, eff_rate;
  logic       f_loss, f_swing, f_emph, f_thr, o_dis, o_rng, o_off, lvl_fix, rate_fix, neg;
  int         mdl [16];
  int         n_fail, num_checks, seed, cycles, i, a;
  logic [7:0] thr_codes [6] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'h81, 8'hFF};

  equalizer_control_register_bank i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .loss_level_pin_code(lpin), .disable_pin(dpin), .loss_range_pin(rngpin),
    .rate_pin_code(rpin), .rate_setting(rset), .loss_level_from_pin(f_loss),
    .swing_from_pin(f_swing), .emphasis_from_pin(f_emph), .threshold_from_pin(f_thr),
    .output_disable(o_dis), .loss_range_select(o_rng), .offset_cancel_off(o_off),
    .loss_level_fixed(lvl_fix), .rate_fixed(rate_fix), .effective_loss_level(eff_lvl),
    .effective_rate(eff_rate), .threshold_shift_mag(mag), .threshold_shift_neg(neg)
  );

  reg_host_model i_host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  function automatic logic [6:0] exp_lvl();
    if (!mdl[0][0] || mdl[0][7]) return lpin;
    if (mdl[11][7]) return 7'(mdl[11]);
    return FIXED_LOSS_CODE;
  endfunction : exp_lvl

  function automatic logic [3:0] exp_rate();
    if (!mdl[0][0]) return rpin;
    if (rset[7]) return rset[3:0];
    return FIXED_RATE_CODE;
  endfunction : exp_rate

  function automatic logic [7:0] exp_read(input int ad);
    case (ad)
      0, 1, 11: return 8'(mdl[ad]);
      14:       return {4'h0, exp_rate()};
      15:       return {1'b0, exp_lvl()};
      default:  return 8'h00;
    endcase
  endfunction : exp_read

  // address decode seen at the edge that takes each read
  always @(posedge sys_clk) begin
    if (reg_rd === 1'b1) check(reg_hit, (reg_addr < 8'h10 && (reg_addr < 8'h02 || reg_addr > 8'h07)));
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic model_write(input int ad, input int d);
    i_host.write_reg(8'(ad), 8'(d));
    if (ad == 0 || ad == 1 || ad == 11) mdl[ad] = d & 8'hFF;
  endtask : model_write

  task automatic read_check(input int ad);
    logic [7:0] d;
    logic       v;
    i_host.read_reg(8'(ad), d, v);
    check(v, 1'b1);
    check(d, exp_read(ad));
  endtask : read_check

  task automatic check_outs();
    int c;
    int rm;
    repeat (3) @(posedge sys_clk);
    #1;
    c  = mdl[1];
    rm = mdl[0] & 1;
    check(f_loss, rm ? mdl[0][7] : 1'b1);
    check(f_swing, rm ? mdl[0][6] : 1'b1);
    check(f_emph, rm ? mdl[0][5] : 1'b1);
    check(f_thr, rm ? mdl[0][4] : 1'b1);
    check(o_dis, rm ? mdl[0][3] : dpin);
    check(o_rng, rm ? mdl[0][2] : rngpin);
    check(o_off, rm ? mdl[0][1] : 1'b0);
    check(eff_lvl, exp_lvl());
    check(eff_rate, exp_rate());
    check(rate_fix, rm && !rset[7]);
    check(lvl_fix, rm && !mdl[0][7] && !mdl[11][7]);
    if (c == 0 || c == 128) check({neg, mag}, 8'h00);
    else if (c < 128) check({neg, mag}, {1'b0, 7'(128 - c)});
    else check({neg, mag}, {1'b1, 7'(c - 128)});
  endtask : check_outs

  task automatic shake_pins();
    @(posedge sys_clk);
    #1;
    lpin   = 7'($random(seed));
    dpin   = 1'($random(seed));
    rngpin = 1'($random(seed));
    rpin   = 4'($random(seed));
    rset   = 8'($random(seed));
  endtask : shake_pins

  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    foreach (mdl[k]) mdl[k] = 0;
  endtask : do_reset

  initial begin
    seed       = 15538;
    n_fail     = 0;
    num_checks = 0;
    cycles     = 0;
    {lpin, dpin, rngpin, rpin, rset} = '0;
    do_reset(6);
    for (a = 0; a < 20; a++) read_check(a);
    shake_pins();
    check_outs();
    for (i = 0; i < 6; i++) begin
      model_write(1, thr_codes[i]);
      check_outs();
    end
    for (i = 0; i < 60; i++) begin
      shake_pins();
      model_write(0, $random(seed));
      model_write(1, $random(seed));
      model_write(11, $random(seed));
      model_write($random(seed) & 8'h1F, $random(seed));
      check_outs();
      read_check(0);
      read_check(1);
      read_check(11);
      read_check(14);
      read_check(15);
      read_check($random(seed) & 8'h3F);
      if (i == 30) begin
        do_reset(2);
        read_check(0);
        check_outs();
      end
    end
    conclude();
  end
endmodule : test_equalizer_control_register_bank

// >>> logic/equalizer_control_register_bank.sv
// Operation
// - master bit 7 set hands loss level to its pin; clear uses register, default
// - master bit 6 set takes output swing from pin; clear uses register, default
// - master bit 5 set takes de-emphasis from pins; clear uses register, default
// - master bit 4 set takes threshold from pin; clear uses register, default
// - master bit 3 disables output driver; resets to zero
// - master bit 2 selects high loss range; zero selects low range, default
// - master bit 1 set disables offset cancellation; zero keeps it, default
// - master bit 0 makes register settings active; zero leaves pin control
// - threshold codes 1..127 shift positive, largest at 1
// - threshold codes 0 and 128 give zero shift; register resets to zero
// - threshold codes 129..255 shift negative, largest at 255
// - address 0x0B holds override bit 7 and level code bits 6..0
// - address 0x0E reads effective rate in bits 3..0, read only
// - address 0x0F reads effective loss level in bits 6..0, read only
// - addresses 0x08..0x0A, 0x0C, 0x0D have no fields
// - level override set uses code; clear applies fixed 50mV level
// - rate override set uses bits 3..0; clear applies fixed bandwidth
`timescale 1ns/1ps
module equalizer_control_register_bank
  import eq_regs_pkg::*;
(
  input  wire logic       sys_clk,              // system clock, 100 MHz
  input  wire logic       rst,                  // sync reset, active high
  input  wire logic       reg_wr,               // write strobe from serial engine
  input  wire logic       reg_rd,               // read strobe from serial engine
  input  wire logic [7:0] reg_addr,             // register address
  input  wire logic [7:0] reg_wdata,            // write data
  output logic      [7:0] reg_rdata,            // read data, one cycle after reg_rd
  output logic            reg_rvalid,           // read data valid pulse
  output wire logic       reg_hit,              // address belongs to this bank
  input  wire logic [6:0] loss_level_pin_code,  // digitized level pin voltage
  input  wire logic       disable_pin,          // external output disable
  input  wire logic       loss_range_pin,       // external loss range select
  input  wire logic [3:0] rate_pin_code,        // pin-selected bandwidth code
  input  wire logic [7:0] rate_setting,         // content of the rate register
  output logic            loss_level_from_pin,  // level follows its pin
  output logic            swing_from_pin,       // swing follows its pin
  output logic            emphasis_from_pin,    // de-emphasis follows its pins
  output logic            threshold_from_pin,   // threshold follows its pin
  output logic            output_disable,       // output driver off
  output logic            loss_range_select,    // high loss assert range
  output logic            offset_cancel_off,    // offset cancellation off
  output logic            loss_level_fixed,     // fixed 50mV level in effect
  output logic            rate_fixed,           // fixed bandwidth in effect
  output logic      [6:0] effective_loss_level, // level code in effect
  output logic      [3:0] effective_rate,       // bandwidth code in effect
  output wire logic [6:0] threshold_shift_mag,  // threshold shift size
  output wire logic       threshold_shift_neg   // threshold shift is negative
);

  function automatic logic addr_is_bank(input logic [7:0] addr);
    return (addr <= LOSS_STATUS_ADDR) &&
           !(addr >= 8'h02 && addr <= 8'h07);
  endfunction : addr_is_bank

  function automatic logic addr_is_reserved(input logic [7:0] addr);
    return (addr == RESERVED_EIGHT_ADDR) || (addr == RESERVED_NINE_ADDR) ||
           (addr == RESERVED_TEN_ADDR)   || (addr == RESERVED_TWLV_ADDR) ||
           (addr == RESERVED_THRT_ADDR);
  endfunction : addr_is_reserved

  logic [7:0] master_control;
  logic [7:0] input_threshold_adjust;
  logic [7:0] signal_loss_level_setting;

  // decode
  wire logic wr_master;
  wire logic wr_threshold;
  wire logic wr_loss_level;
  wire logic rd_reserved;

  // 0x02..0x07 live elsewhere; hit lets the engine route them
  assign reg_hit       = addr_is_bank(reg_addr);
  assign wr_master     = reg_wr && (reg_addr == MASTER_CONTROL_ADDR);
  assign wr_threshold  = reg_wr && (reg_addr == THRESHOLD_ADDR);
  assign wr_loss_level = reg_wr && (reg_addr == LOSS_LEVEL_ADDR);
  assign rd_reserved   = addr_is_reserved(reg_addr);

  // only three writable registers; everything else drops the write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      master_control <= MASTER_CONTROL_RESET;
    end else if (wr_master) begin
      master_control <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      input_threshold_adjust <= THRESHOLD_RESET;
    end else if (wr_threshold) begin
      input_threshold_adjust <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      signal_loss_level_setting <= LOSS_LEVEL_RESET;
    end else if (wr_loss_level) begin
      signal_loss_level_setting <= reg_wdata;
    end
  end

  // field views
  wire logic register_control_enable;
  wire logic loss_level_pin_select;
  wire logic swing_pin_select;
  wire logic emphasis_pin_select;
  wire logic threshold_pin_select;
  wire logic loss_level_override;
  wire logic rate_override;

  assign register_control_enable = master_control[REG_CTRL_BIT];
  assign loss_level_pin_select   = master_control[LOSS_PIN_BIT];
  assign swing_pin_select        = master_control[SWING_PIN_BIT];
  assign emphasis_pin_select     = master_control[EMPH_PIN_BIT];
  assign threshold_pin_select    = master_control[THRESH_PIN_BIT];
  assign loss_level_override     = signal_loss_level_setting[LOSS_OVERRIDE_BIT];
  assign rate_override           = rate_setting[RATE_OVERRIDE_BIT];

  // source selection
  wire logic       next_loss_level_from_pin;
  wire logic       next_swing_from_pin;
  wire logic       next_emphasis_from_pin;
  wire logic       next_threshold_from_pin;
  wire logic       next_output_disable;
  wire logic       next_loss_range_select;
  wire logic       next_offset_cancel_off;
  wire logic       next_loss_level_fixed;
  wire logic       next_rate_fixed;
  wire logic [6:0] next_effective_loss_level;
  wire logic [3:0] next_effective_rate;

  // pin selects only count once register control is on
  assign next_loss_level_from_pin = !register_control_enable || loss_level_pin_select;
  assign next_swing_from_pin      = !register_control_enable || swing_pin_select;
  assign next_emphasis_from_pin   = !register_control_enable || emphasis_pin_select;
  assign next_threshold_from_pin  = !register_control_enable || threshold_pin_select;

  assign next_output_disable    = register_control_enable ?
                                  master_control[DISABLE_BIT] : disable_pin;
  assign next_loss_range_select = register_control_enable ?
                                  master_control[RANGE_BIT] : loss_range_pin;
  assign next_offset_cancel_off = register_control_enable &&
                                  master_control[OFFSET_OFF_BIT];

  assign next_loss_level_fixed     = !next_loss_level_from_pin && !loss_level_override;
  assign next_effective_loss_level = next_loss_level_from_pin ? loss_level_pin_code :
                                     loss_level_override ? signal_loss_level_setting[6:0] :
                                     FIXED_LOSS_CODE;

  // the rate register has no pin select bit; only the global mode gates it
  assign next_rate_fixed     = register_control_enable && !rate_override;
  assign next_effective_rate = !register_control_enable ? rate_pin_code :
                               rate_override ? rate_setting[3:0] :
                               FIXED_RATE_CODE;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loss_level_from_pin <= 1'b1;
      swing_from_pin      <= 1'b1;
      emphasis_from_pin   <= 1'b1;
      threshold_from_pin  <= 1'b1;
      output_disable      <= 1'b0;
      loss_range_select   <= 1'b0;
      offset_cancel_off   <= 1'b0;
    end else begin
      loss_level_from_pin <= next_loss_level_from_pin;
      swing_from_pin      <= next_swing_from_pin;
      emphasis_from_pin   <= next_emphasis_from_pin;
      threshold_from_pin  <= next_threshold_from_pin;
      output_disable      <= next_output_disable;
      loss_range_select   <= next_loss_range_select;
      offset_cancel_off   <= next_offset_cancel_off;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loss_level_fixed     <= 1'b0;
      rate_fixed           <= 1'b0;
      effective_loss_level <= FIXED_LOSS_CODE;
      effective_rate       <= FIXED_RATE_CODE;
    end else begin
      loss_level_fixed     <= next_loss_level_fixed;
      rate_fixed           <= next_rate_fixed;
      effective_loss_level <= next_effective_loss_level;
      effective_rate       <= next_effective_rate;
    end
  end

  // threshold code decode
  threshold_if thr ();

  assign thr.code            = input_threshold_adjust;
  assign threshold_shift_mag = thr.magnitude;
  assign threshold_shift_neg = thr.negative;

  threshold_decoder u_threshold_decoder (
    .sys_clk (sys_clk),
    .rst     (rst),
    .thr     (thr)
  );

  // read path
  wire logic [7:0] next_rdata;

  // status reads show what is applied, not what was last written
  assign next_rdata =
    (reg_addr == MASTER_CONTROL_ADDR) ? master_control :
    (reg_addr == THRESHOLD_ADDR)      ? input_threshold_adjust :
    (reg_addr == LOSS_LEVEL_ADDR)     ? signal_loss_level_setting :
    (reg_addr == RATE_STATUS_ADDR)    ? {4'h0, effective_rate} :
    (reg_addr == LOSS_STATUS_ADDR)    ? {1'b0, effective_loss_level} :
    8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata  <= READ_DATA_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? next_rdata : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence master_write_s(int pos, logic val);
    wr_master && reg_wdata[REG_CTRL_BIT] && reg_wdata[pos] == val;
  endsequence

  sequence master_quiet_s;
    !wr_master;
  endsequence

  loss_pin_hand_a: assert property (
    master_write_s(LOSS_PIN_BIT, 1'b1) ##1 master_quiet_s |=> loss_level_from_pin)
    else $error("loss level not handed to pin");

  swing_reg_a: assert property (
    master_write_s(SWING_PIN_BIT, 1'b0) ##1 master_quiet_s |=> !swing_from_pin)
    else $error("swing not from register");

  emphasis_pin_a: assert property (
    master_write_s(EMPH_PIN_BIT, 1'b1) ##1 master_quiet_s |=> emphasis_from_pin)
    else $error("emphasis not from pins");

  threshold_reg_a: assert property (
    master_write_s(THRESH_PIN_BIT, 1'b0) ##1 master_quiet_s |=> !threshold_from_pin)
    else $error("threshold not from register");

  output_off_a: assert property (
    master_write_s(DISABLE_BIT, 1'b1) ##1 master_quiet_s |=> output_disable)
    else $error("output not disabled");

  range_high_a: assert property (
    master_write_s(RANGE_BIT, 1'b1) ##1 master_quiet_s |=> loss_range_select)
    else $error("loss range not high");

  offset_off_a: assert property (
    master_write_s(OFFSET_OFF_BIT, 1'b1) ##1 master_quiet_s |=> offset_cancel_off)
    else $error("offset cancellation still on");

  pin_mode_all_a: assert property (
    (wr_master && !reg_wdata[REG_CTRL_BIT]) ##1 master_quiet_s |=>
      (loss_level_from_pin && swing_from_pin && emphasis_from_pin &&
       threshold_from_pin && !offset_cancel_off))
    else $error("pin mode not applied");

  pin_disable_a: assert property (
    !register_control_enable |=> output_disable == $past(disable_pin))
    else $error("disable pin not followed");

  fixed_level_a: assert property (
    (register_control_enable && !loss_level_pin_select && !loss_level_override)
      |=> (loss_level_fixed && effective_loss_level == FIXED_LOSS_CODE))
    else $error("fixed loss level not applied");

  fixed_rate_a: assert property (
    (register_control_enable && !rate_override)
      |=> (rate_fixed && effective_rate == FIXED_RATE_CODE))
    else $error("fixed bandwidth not applied");

  rate_read_a: assert property (
    (reg_rd && reg_addr == RATE_STATUS_ADDR) |=>
      (reg_rvalid && reg_rdata == {4'h0, $past(effective_rate)}))
    else $error("rate status read wrong");

  level_read_a: assert property (
    (reg_rd && reg_addr == LOSS_STATUS_ADDR) |=>
      (reg_rvalid && reg_rdata[7] == 1'b0 && reg_rdata[6:0] == $past(effective_loss_level)))
    else $error("level status read wrong");

  reserved_read_a: assert property (
    (reg_rd && rd_reserved) |=> (reg_rvalid && reg_rdata == 8'h00))
    else $error("reserved read not zero");

  ignored_write_a: assert property (
    (reg_wr && !wr_master && !wr_threshold && !wr_loss_level) |=>
      (master_control == $past(master_control) &&
       input_threshold_adjust == $past(input_threshold_adjust) &&
       signal_loss_level_setting == $past(signal_loss_level_setting)))
    else $error("ignored write changed a register");

  level_store_a: assert property (
    wr_loss_level |=> signal_loss_level_setting == $past(reg_wdata))
    else $error("level setting not stored");

  master_store_a: assert property (
    wr_master |=> master_control == $past(reg_wdata))
    else $error("master control not stored");

  threshold_store_a: assert property (
    wr_threshold |=> input_threshold_adjust == $past(reg_wdata))
    else $error("threshold code not stored");

  master_read_a: assert property (
    (reg_rd && reg_addr == MASTER_CONTROL_ADDR) |=> reg_rdata == $past(master_control))
    else $error("master control read wrong");

  read_valid_a: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read valid missing");

  valid_quiet_a: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without read");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  pin_range_a: assert property (
    !register_control_enable |=> loss_range_select == $past(loss_range_pin))
    else $error("range pin not followed");

  pin_level_a: assert property (
    (!register_control_enable || loss_level_pin_select) |=>
      effective_loss_level == $past(loss_level_pin_code))
    else $error("level pin not followed");

  pin_rate_a: assert property (
    !register_control_enable |=> effective_rate == $past(rate_pin_code))
    else $error("rate pin not followed");

endmodule : equalizer_control_register_bank

// >>> logic/threshold_decoder.sv
`timescale 1ns/1ps
module threshold_decoder
  import eq_regs_pkg::*;
(
  input  wire logic    sys_clk, // system clock
  input  wire logic    rst,     // sync reset, active high
  threshold_if.decoder thr      // code in, shift out
);

  wire logic [7:0] pos_span;
  wire logic       is_zero;
  wire logic [6:0] next_magnitude;
  wire logic       next_negative;

  // both 0 and 128 mean no shift
  assign is_zero        = (thr.code[6:0] == 7'h00);
  assign pos_span       = THRESHOLD_MID_CODE - thr.code;
  assign next_magnitude = is_zero     ? 7'h00 :
                          thr.code[7] ? thr.code[6:0] :
                                        pos_span[6:0];
  assign next_negative  = thr.code[7] && !is_zero;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thr.magnitude <= 7'h00;
      thr.negative  <= 1'b0;
    end else begin
      thr.magnitude <= next_magnitude;
      thr.negative  <= next_negative;
    end
  end

  positive_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
    (thr.code > 8'h00 && thr.code < 8'h80) |=> (!thr.negative &&
      thr.magnitude == 7'($past(THRESHOLD_MID_CODE - thr.code))))
    else $error("positive threshold shift wrong");

  zero_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
    (thr.code == 8'h00 || thr.code == 8'h80) |=> (thr.magnitude == 7'h00 && !thr.negative))
    else $error("zero threshold shift wrong");

  negative_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
    (thr.code > 8'h80) |=> (thr.negative && thr.magnitude == $past(thr.code[6:0])))
    else $error("negative threshold shift wrong");

endmodule : threshold_decoder

// >>> pkg/eq_regs_pkg.sv
package eq_regs_pkg;

  // register addresses
  localparam logic [7:0] MASTER_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] THRESHOLD_ADDR      = 8'h01;
  localparam logic [7:0] RESERVED_EIGHT_ADDR = 8'h08;
  localparam logic [7:0] RESERVED_NINE_ADDR  = 8'h09;
  localparam logic [7:0] RESERVED_TEN_ADDR   = 8'h0A;
  localparam logic [7:0] LOSS_LEVEL_ADDR     = 8'h0B;
  localparam logic [7:0] RESERVED_TWLV_ADDR  = 8'h0C;
  localparam logic [7:0] RESERVED_THRT_ADDR  = 8'h0D;
  localparam logic [7:0] RATE_STATUS_ADDR    = 8'h0E;
  localparam logic [7:0] LOSS_STATUS_ADDR    = 8'h0F;

  // master control field positions
  localparam int LOSS_PIN_BIT   = 7;
  localparam int SWING_PIN_BIT  = 6;
  localparam int EMPH_PIN_BIT   = 5;
  localparam int THRESH_PIN_BIT = 4;
  localparam int DISABLE_BIT    = 3;
  localparam int RANGE_BIT      = 2;
  localparam int OFFSET_OFF_BIT = 1;
  localparam int REG_CTRL_BIT   = 0;

  // override bits of level and rate settings
  localparam int LOSS_OVERRIDE_BIT = 7;
  localparam int RATE_OVERRIDE_BIT = 7;

  // reset values
  localparam logic [7:0] MASTER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET      = 8'h00;
  localparam logic [7:0] LOSS_LEVEL_RESET     = 8'h00;
  localparam logic [7:0] READ_DATA_RESET      = 8'h00;

  // threshold code landmarks
  localparam logic [7:0] THRESHOLD_MID_CODE = 8'h80;

  // fixed settings used when an override bit is clear
  localparam int         FIXED_LOSS_MV   = 50;
  localparam logic [6:0] FIXED_LOSS_CODE = 7'h00;
  localparam logic [3:0] FIXED_RATE_CODE = 4'h0;

endpackage : eq_regs_pkg

// >>> pkg/threshold_if.sv
`timescale 1ns/1ps
interface threshold_if;
  logic [7:0] code;
  logic [6:0] magnitude;
  logic       negative;
  modport decoder (input code, output magnitude, output negative);
  modport bank (output code, input magnitude, input negative);
endinterface : threshold_if
